/* uph_pkg.sv */
// constants and types shared by the host endpoint and power control block
package uph_pkg;
  // timing
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned VBUS_GLITCH_NS  = 1000;
  // longest ignored drop rounds down to whole cycles
  localparam int unsigned VBUS_GLITCH_CYC = (VBUS_GLITCH_NS * CLK_MHZ) / 1000;

  // hub routing word layout
  localparam int unsigned HUB_WORD_W   = 16;
  localparam int unsigned HUB_ADDR_LSB = 0;
  localparam int unsigned HUB_ADDR_W   = 7;
  localparam int unsigned HUB_PORT_LSB = 8;
  localparam int unsigned HUB_PORT_W   = 7;

  // endpoint zero carries every control transfer
  localparam int unsigned ENDPOINT_ZERO = 0;

  typedef enum logic [1:0] {
    endpoint_low_speed_sel,
    endpoint_full_speed_sel,
    endpoint_high_speed_sel
  } uph_speed_type;

  typedef enum logic {
    host_in_direction,
    host_out_direction
  } uph_dir_type;

  typedef enum logic {
    fault_active_low,
    fault_active_high
  } uph_fault_level_type;

  typedef enum logic [1:0] {
    fault_action_none,
    fault_action_tristate,
    fault_action_drive_low,
    fault_action_drive_high
  } uph_fault_action_type;

  typedef enum logic [1:0] {
    pwr_en_manual_low,
    pwr_en_manual_high,
    pwr_en_session_low,
    pwr_en_session_high
  } uph_pwr_mode_type;

  // reset values
  localparam uph_speed_type SPEED_RST   = endpoint_full_speed_sel;
  localparam logic          PING_EN_RST = 1'b1;
endpackage

/* uph_ep_mem.sv */
// routing and speed store, one entry per endpoint direction
`timescale 1ns/1ps
module uph_ep_mem #(
  parameter int unsigned NUM_EP = 8,
  parameter int unsigned EP_W   = 3
) (
  // clock
  input  wire logic                       mclk,
  // writes
  input  wire logic                       route_we,
  input  wire logic                       speed_we,
  input  wire logic [EP_W:0]              wr_idx,
  input  wire logic [uph_pkg::HUB_WORD_W-1:0] wr_route,
  input  wire uph_pkg::uph_speed_type     wr_speed,
  // software read port
  input  wire logic [EP_W:0]              a_idx,
  output      logic [uph_pkg::HUB_WORD_W-1:0] a_route,
  output      uph_pkg::uph_speed_type     a_speed,
  // scheduler read port
  input  wire logic [EP_W:0]              b_idx,
  output      logic [uph_pkg::HUB_WORD_W-1:0] b_route,
  output      uph_pkg::uph_speed_type     b_speed
);
  import uph_pkg::*;

  typedef struct packed {
    logic [2*NUM_EP-1:0][HUB_WORD_W-1:0] route;
    logic [2*NUM_EP-1:0][1:0]            speed;
    logic [HUB_WORD_W-1:0]               a_route;
    logic [1:0]                          a_speed;
    logic [HUB_WORD_W-1:0]               b_route;
    logic [1:0]                          b_speed;
  } uph_mem_type;

  uph_mem_type m_r;
  uph_mem_type m_nxt;

  // separate field enables avoid a read-modify-write
  always_comb begin
    m_nxt = m_r;
    if (route_we) begin
      m_nxt.route[wr_idx] = wr_route;
    end
    if (speed_we) begin
      m_nxt.speed[wr_idx] = wr_speed;
    end
    m_nxt.a_route = m_r.route[a_idx];
    m_nxt.a_speed = m_r.speed[a_idx];
    m_nxt.b_route = m_r.route[b_idx];
    m_nxt.b_speed = m_r.speed[b_idx];
  end

  // storage has no reset; entries are written before use
  always_ff @(posedge mclk) begin
    m_r <= m_nxt;
  end

  assign a_route = m_r.a_route;
  assign a_speed = uph_speed_type'(m_r.a_speed);
  assign b_route = m_r.b_route;
  assign b_speed = uph_speed_type'(m_r.b_speed);
endmodule // uph_ep_mem

/* uph_vbus_filt.sv */
// vbus glitch filter: hides short drops of the valid level
`timescale 1ns/1ps
module uph_vbus_filt (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // control and level
  input  wire logic filt_en,
  input  wire logic vbus_raw,
  output      logic vbus_ok
);
  import uph_pkg::*;

  localparam int unsigned CNT_W = $clog2(VBUS_GLITCH_CYC + 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             ok;
  } uph_filt_type;

  uph_filt_type f_r;
  uph_filt_type f_nxt;

  // count low cycles; with filt_en set, only a drop outlasting the window is passed on, without it any drop is
  always_comb begin
    f_nxt = f_r;
    if (vbus_raw) begin
      f_nxt.cnt = '0;
      f_nxt.ok  = 1'b1;
    end else if (!filt_en) begin
      f_nxt.ok = 1'b0;
    end else if (f_r.cnt < CNT_W'(VBUS_GLITCH_CYC)) begin
      f_nxt.cnt = f_r.cnt + CNT_W'(1);
    end else begin
      f_nxt.ok = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  assign vbus_ok = f_r.ok;
endmodule // uph_vbus_filt

/* uph_top.sv */
// host endpoint routing, IN scheduling and external power control
`timescale 1ns/1ps
// Overview of operation
// - control data and status stages ping only while enabled
// - ping setting applies to endpoint zero only
// - separate IN and OUT speed per endpoint
// - hub word: address bits 0-6, port bits 8-14
// - hub word write also sets speed, low or full
// - stored hub word reads back
// - control bit forces host mode
// - fault pin level selectable
// - fault action on power enable: none, tristate, low, high
// - manual mode: software enable drives chosen level
// - session mode: active session drives chosen level
// - optional filter ignores short vbus drops
// - software set and clear switch power enable
// - fault detection has its own enable
// - IN request schedules an IN transaction
// - status clear clears exactly the masked bits
// - pending IN request can be cancelled
module uph_top #(
  parameter int unsigned NUM_EP = 8,
  parameter int unsigned EP_W   = 3,
  parameter int unsigned STAT_W = 8
) (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst,
  // role
  input  wire logic                        host_force,
  input  wire logic                        id_host,
  output      logic                        role_override_select,
  output      logic                        host_mode,
  // ping control
  input  wire logic                        ping_wr,
  input  wire logic [EP_W-1:0]             ping_ep,
  input  wire logic                        ping_val,
  output      logic                        ping_en,
  // speed control
  input  wire logic                        speed_wr,
  input  wire logic [EP_W-1:0]             speed_ep,
  input  wire uph_pkg::uph_dir_type        speed_dir,
  input  wire uph_pkg::uph_speed_type      speed_val,
  // hub routing write
  input  wire logic                        hub_wr,
  input  wire logic [EP_W-1:0]             hub_ep,
  input  wire uph_pkg::uph_dir_type        hub_dir,
  input  wire logic [uph_pkg::HUB_WORD_W-1:0] hub_word,
  input  wire logic                        hub_low_speed,
  // readback
  input  wire logic                        rd_req,
  input  wire logic [EP_W-1:0]             rd_ep,
  input  wire uph_pkg::uph_dir_type        rd_dir,
  output      logic                        rd_valid,
  output      logic [uph_pkg::HUB_WORD_W-1:0] rd_hub_word,
  output      uph_pkg::uph_speed_type      rd_speed,
  output      logic [STAT_W-1:0]           rd_status,
  // endpoint status
  input  wire logic                        stat_set,
  input  wire logic [EP_W-1:0]             stat_set_ep,
  input  wire logic [STAT_W-1:0]           stat_set_bits,
  input  wire logic                        stat_clr,
  input  wire logic [EP_W-1:0]             stat_clr_ep,
  input  wire logic [STAT_W-1:0]           stat_clr_mask,
  // IN requests
  input  wire logic                        in_req,
  input  wire logic                        in_cancel,
  input  wire logic [EP_W-1:0]             in_ep,
  output      logic [NUM_EP-1:0]           in_pending,
  // link side
  input  wire logic                        link_ready,
  input  wire logic                        link_done,
  output      logic                        tx_start,
  output      logic [EP_W-1:0]             tx_ep,
  output      uph_pkg::uph_speed_type      tx_speed,
  output      logic [uph_pkg::HUB_ADDR_W-1:0] tx_hub_addr,
  output      logic [uph_pkg::HUB_PORT_W-1:0] tx_hub_port,
  output      logic                        tx_ping,
  // power configuration
  input  wire uph_pkg::uph_fault_level_type   fault_level,
  input  wire uph_pkg::uph_fault_action_type  fault_action,
  input  wire uph_pkg::uph_pwr_mode_type      pwr_mode,
  input  wire logic                        vbus_glitch_filter_en,
  input  wire logic                        fault_det_en,
  input  wire logic                        pwr_set,
  input  wire logic                        pwr_clr,
  input  wire logic                        fault_clr,
  input  wire logic                        session_active,
  // power pins
  input  wire logic                        power_fault_input,
  input  wire logic                        vbus_valid_raw,
  output      logic                        external_power_enable_out,
  output      logic                        external_power_enable_oe,
  output      logic                        fault_status,
  output      logic                        vbus_error
);
  import uph_pkg::*;

  if (NUM_EP < 1 || NUM_EP > (1 << EP_W) || STAT_W < 1) begin : g_bad_param
    $error("uph_top: NUM_EP must fit EP_W and STAT_W must be nonzero");
  end

  typedef enum logic [1:0] {
    SCH_IDLE,
    SCH_LOOK,
    SCH_ISSUE,
    SCH_WAIT
  } uph_sched_type;

  typedef struct packed {
    logic [NUM_EP-1:0][STAT_W-1:0] stat;
    logic [NUM_EP-1:0]             pend;
    logic                          ping_en;
    logic                          sw_pwr;
    logic                          fault;
    logic                          role;
    logic                          host;
    logic                          epen;
    logic                          epen_oe;
    logic                          vbus_err;
    uph_sched_type                 st;
    logic [EP_W-1:0]               cur_ep;
    logic                          tx_start;
    logic [EP_W-1:0]               tx_ep;
    uph_speed_type                 tx_speed;
    logic [HUB_ADDR_W-1:0]         tx_hub_addr;
    logic [HUB_PORT_W-1:0]         tx_hub_port;
    logic                          tx_ping;
    logic                          rd_valid;
    logic [STAT_W-1:0]             rd_stat;
  } uph_state_type;

  uph_state_type s_r;
  uph_state_type s_nxt;

  logic [HUB_WORD_W-1:0] b_route;
  uph_speed_type         b_speed;
  logic                  vbus_ok;
  logic [EP_W:0]         wr_idx;
  logic [HUB_WORD_W-1:0] wr_route;
  uph_speed_type         wr_speed;

  // lowest numbered pending endpoint wins the link
  function automatic logic [EP_W-1:0] first_pend(input logic [NUM_EP-1:0] p);
    logic [EP_W-1:0] r;
    r = '0;
    for (int i = NUM_EP - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = EP_W'(i);
      end
    end
    return r;
  endfunction

  // entry index from endpoint and direction
  function automatic logic [EP_W:0] ep_idx(input logic [EP_W-1:0] ep, input uph_dir_type d);
    return {ep, d};
  endfunction

  // routing word keeps only its address and port fields
  always_comb begin
    wr_route = '0;
    wr_route[HUB_ADDR_LSB +: HUB_ADDR_W] = hub_word[HUB_ADDR_LSB +: HUB_ADDR_W];
    wr_route[HUB_PORT_LSB +: HUB_PORT_W] = hub_word[HUB_PORT_LSB +: HUB_PORT_W];
    wr_idx   = hub_wr ? ep_idx(hub_ep, hub_dir) : ep_idx(speed_ep, speed_dir);
    // a routing write also sets speed; it wins over a same-cycle speed write
    wr_speed = hub_wr ? (hub_low_speed ? endpoint_low_speed_sel
                                       : endpoint_full_speed_sel)
                      : speed_val;
  end

  uph_ep_mem #(
    .NUM_EP (NUM_EP),
    .EP_W   (EP_W)
  ) u_mem (
    .mclk     (mclk),
    .route_we (hub_wr),
    .speed_we (hub_wr | speed_wr),
    .wr_idx   (wr_idx),
    .wr_route (wr_route),
    .wr_speed (wr_speed),
    .a_idx    (ep_idx(rd_ep, rd_dir)),
    .a_route  (rd_hub_word),
    .a_speed  (rd_speed),
    .b_idx    (ep_idx(s_r.cur_ep, host_in_direction)),
    .b_route  (b_route),
    .b_speed  (b_speed)
  );

  uph_vbus_filt u_filt (
    .mclk     (mclk),
    .rst      (rst),
    .filt_en  (vbus_glitch_filter_en),
    .vbus_raw (vbus_valid_raw),
    .vbus_ok  (vbus_ok)
  );

  // next state of the whole block
  always_comb begin
    logic fault_now;
    logic pwr_on;
    logic lvl_high;
    fault_now = 1'b0;
    pwr_on    = 1'b0;
    lvl_high  = 1'b0;
    s_nxt     = s_r;

    // role and ping control
    s_nxt.role = host_force;
    s_nxt.host = host_force | id_host;
    if (ping_wr && ping_ep == EP_W'(ENDPOINT_ZERO)) begin
      s_nxt.ping_en = ping_val;
    end

    // status: clear by mask, then a same-cycle set wins
    for (int e = 0; e < NUM_EP; e++) begin
      if (stat_clr && stat_clr_ep == EP_W'(e)) begin
        s_nxt.stat[e] = s_r.stat[e] & ~stat_clr_mask;
      end
      if (stat_set && stat_set_ep == EP_W'(e)) begin
        s_nxt.stat[e] = s_nxt.stat[e] | stat_set_bits;
      end
    end
    s_nxt.rd_valid = rd_req;
    s_nxt.rd_stat  = s_r.stat[rd_ep];

    // pending requests: cancel first, new request wins
    if (in_cancel) begin
      s_nxt.pend[in_ep] = 1'b0;
    end

    // scheduler
    s_nxt.tx_start = 1'b0;
    case (s_r.st)
      SCH_IDLE: begin
        // wait for host mode
        if (s_r.host && link_ready && |s_nxt.pend) begin
          s_nxt.cur_ep = first_pend(s_nxt.pend);
          s_nxt.st     = SCH_LOOK;
        end
      end
      SCH_LOOK: begin
        s_nxt.st = SCH_ISSUE;
      end
      SCH_ISSUE: begin
        // a cancel during lookup drops the transaction
        if (!s_nxt.pend[s_r.cur_ep]) begin
          s_nxt.st = SCH_IDLE;
        end else begin
          s_nxt.pend[s_r.cur_ep] = 1'b0;
          s_nxt.tx_start    = 1'b1;
          s_nxt.tx_ep       = s_r.cur_ep;
          s_nxt.tx_speed    = b_speed;
          s_nxt.tx_hub_addr = b_route[HUB_ADDR_LSB +: HUB_ADDR_W];
          s_nxt.tx_hub_port = b_route[HUB_PORT_LSB +: HUB_PORT_W];
          // ping: endpoint zero at high speed only
          s_nxt.tx_ping     = s_r.ping_en && b_speed == endpoint_high_speed_sel
                              && s_r.cur_ep == EP_W'(ENDPOINT_ZERO);
          s_nxt.st          = SCH_WAIT;
        end
      end
      SCH_WAIT: begin
        if (link_done) begin
          s_nxt.st = SCH_IDLE;
        end
      end
      default: begin
        s_nxt.st = SCH_IDLE;
      end
    endcase
    if (in_req) begin
      s_nxt.pend[in_ep] = 1'b1;
    end

    // software power switch; set wins over clear
    if (pwr_clr) begin
      s_nxt.sw_pwr = 1'b0;
    end
    if (pwr_set) begin
      s_nxt.sw_pwr = 1'b1;
    end

    // fault at the selected level, when enabled
    fault_now = fault_det_en &&
                (power_fault_input == (fault_level == fault_active_high));
    if (!fault_det_en) begin
      s_nxt.fault = 1'b0;
    end else if (fault_now) begin
      s_nxt.fault = 1'b1;
    end else if (fault_clr) begin
      s_nxt.fault = 1'b0;
    end

    // power enable source and level
    case (pwr_mode)
      pwr_en_manual_low: begin
        pwr_on   = s_r.sw_pwr;
        lvl_high = 1'b0;
      end
      pwr_en_manual_high: begin
        pwr_on   = s_r.sw_pwr;
        lvl_high = 1'b1;
      end
      pwr_en_session_low: begin
        pwr_on   = session_active;
        lvl_high = 1'b0;
      end
      default: begin
        pwr_on   = session_active;
        lvl_high = 1'b1;
      end
    endcase
    s_nxt.epen    = pwr_on ? lvl_high : ~lvl_high;
    s_nxt.epen_oe = 1'b1;

    // fault applies the selected action to the pin
    if (s_nxt.fault) begin
      case (fault_action)
        fault_action_tristate: begin
          s_nxt.epen_oe = 1'b0;
        end
        fault_action_drive_low: begin
          s_nxt.epen = 1'b0;
        end
        fault_action_drive_high: begin
          s_nxt.epen = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // vbus error only while power on
    s_nxt.vbus_err = pwr_on && !vbus_ok;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r         <= '0;
      s_r.ping_en <= PING_EN_RST;
      s_r.st      <= SCH_IDLE;
      s_r.tx_speed <= SPEED_RST;
      s_r.epen    <= 1'b1;
      s_r.epen_oe <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign role_override_select = s_r.role;
  assign host_mode = s_r.host;
  assign ping_en = s_r.ping_en;
  assign rd_valid = s_r.rd_valid;
  assign rd_status = s_r.rd_stat;
  assign in_pending = s_r.pend;
  assign tx_start = s_r.tx_start;
  assign tx_ep = s_r.tx_ep;
  assign tx_speed = s_r.tx_speed;
  assign tx_hub_addr = s_r.tx_hub_addr;
  assign tx_hub_port = s_r.tx_hub_port;
  assign tx_ping = s_r.tx_ping;
  assign external_power_enable_out = s_r.epen;
  assign external_power_enable_oe = s_r.epen_oe;
  assign fault_status = s_r.fault;
  assign vbus_error = s_r.vbus_err;
endmodule // uph_top

/* uph_top_properties.sv */
// port assertions for uph_top
`timescale 1ns/1ps
module uph_top_properties
  import uph_pkg::*;
#(
  parameter int unsigned NUM_EP = 8,
  parameter int unsigned EP_W   = 3
) (
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 rst,
  // role, ping and readback
  input wire logic                 host_force,
  input wire logic                 host_mode,
  input wire logic                 role_override_select,
  input wire logic                 ping_wr,
  input wire logic [EP_W-1:0]      ping_ep,
  input wire logic                 ping_val,
  input wire logic                 ping_en,
  input wire logic                 rd_req,
  input wire logic                 rd_valid,
  // IN scheduling
  input wire logic                 in_req,
  input wire logic                 in_cancel,
  input wire logic [EP_W-1:0]      in_ep,
  input wire logic [NUM_EP-1:0]    in_pending,
  input wire logic                 tx_start,
  input wire logic [EP_W-1:0]      tx_ep,
  input wire logic                 tx_ping,
  // power
  input wire uph_fault_level_type  fault_level,
  input wire uph_fault_action_type fault_action,
  input wire logic                 fault_det_en,
  input wire logic                 power_fault_input,
  input wire logic                 fault_status,
  input wire logic                 external_power_enable_oe
);
  // one domain
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_ping_ep0; ping_wr && ping_ep == '0 |=> ping_en == $past(ping_val); endproperty
  a_ping_ep0: assert property (p_ping_ep0) else $error("ping setting not stored");
  property p_ping_other; ping_wr && ping_ep != '0 |=> $stable(ping_en); endproperty
  a_ping_other: assert property (p_ping_other) else $error("ping taken off ep0");
  property p_tx_ping; tx_start && tx_ep != '0 |-> !tx_ping; endproperty
  a_tx_ping: assert property (p_tx_ping) else $error("ping on non-control ep");
  property p_rd; rd_req |=> rd_valid; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_in; in_req |=> in_pending[$past(in_ep)]; endproperty
  a_in: assert property (p_in) else $error("IN request not pending");
  property p_cancel; in_cancel && !in_req |=> !in_pending[$past(in_ep)]; endproperty
  a_cancel: assert property (p_cancel) else $error("cancel left request");
  property p_tx; tx_start |-> host_mode && !in_pending[tx_ep]; endproperty
  a_tx: assert property (p_tx) else $error("bad issue");
  property p_role; host_force |=> role_override_select && host_mode; endproperty
  a_role: assert property (p_role) else $error("host mode not forced");
  property p_fdet; fault_det_en && power_fault_input == fault_level |=> fault_status; endproperty
  a_fdet: assert property (p_fdet) else $error("fault missed");
  property p_foff; !fault_det_en |=> !fault_status; endproperty
  a_foff: assert property (p_foff) else $error("fault while detection off");
  property p_tri;
    fault_status && $past(fault_action) == fault_action_tristate |-> !external_power_enable_oe;
  endproperty
  a_tri: assert property (p_tri) else $error("pin not released on fault");
  property p_oe; !fault_status |-> external_power_enable_oe; endproperty
  a_oe: assert property (p_oe) else $error("pin released without fault");

  // main scenarios
  c_ping: cover property (tx_start && tx_ping);
  c_fault: cover property ($rose(fault_status));
  c_cancel: cover property (in_cancel && !in_req);
endmodule // uph_top_properties

/* uph_link_model.sv */
// far side link model
`timescale 1ns/1ps
module uph_link_model (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // controller side
  input  wire logic tx_start,
  output      logic link_ready,
  output      logic link_done,
  // pacing
  input  wire logic slow
);
  logic [7:0] cnt_r;
  logic       busy_r;
  // busy until the done pulse
  always_ff @(posedge mclk) begin
    link_done <= 1'b0;
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r  <= 8'h00;
    end else if (tx_start) begin
      busy_r <= 1'b1;
      cnt_r  <= slow ? 8'h28 : 8'h02;
    end else if (busy_r && cnt_r == 8'h00) begin
      busy_r    <= 1'b0;
      link_done <= 1'b1;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign link_ready = !busy_r && !rst;
endmodule // uph_link_model

/* tb.sv */
// testbench for uph_top
`timescale 1ns/1ps
module tb;
  import uph_pkg::*;
  localparam int unsigned NUM_EP = 8;
  localparam int unsigned EP_W   = 3;
  // inputs
  logic mclk = '0, rst = '1, host_force = '0, ping_wr = '0, ping_val = '0, speed_wr = '0;
  logic hub_wr = '0, hub_low_speed = '0, rd_req = '0, stat_set = '0, stat_clr = '0, in_req = '0;
  logic in_cancel = '0, slow = '0, vbus_glitch_filter_en = '0, fault_det_en = '0, pwr_set = '0;
  logic pwr_clr = '0, fault_clr = '0, session_active = '0, power_fault_input = '0;
  logic vbus_valid_raw = '1;
  logic [EP_W-1:0] ping_ep = '0, speed_ep = '0, hub_ep = '0, rd_ep = '0, in_ep = '0;
  logic [EP_W-1:0] stat_set_ep = '0, stat_clr_ep = '0, tx_ep;
  logic [15:0] hub_word = '0, rd_hub_word;
  logic [7:0] stat_set_bits = '0, stat_clr_mask = '0, rd_status;
  uph_dir_type speed_dir = host_in_direction, hub_dir = host_in_direction;
  uph_dir_type rd_dir = host_in_direction;
  uph_speed_type speed_val = endpoint_full_speed_sel, rd_speed, tx_speed;
  uph_fault_level_type fault_level = fault_active_high;
  uph_fault_action_type fault_action = fault_action_none;
  uph_pwr_mode_type pwr_mode = pwr_en_manual_high;
  // design outputs
  logic role_override_select, host_mode, ping_en, rd_valid, link_ready, link_done, tx_start;
  logic tx_ping, external_power_enable_out, external_power_enable_oe, fault_status, vbus_error;
  logic [6:0] tx_hub_addr, tx_hub_port;
  logic [NUM_EP-1:0] in_pending;
  // bookkeeping
  int fails = 0, checked = 0;
  logic [31:0] seed = 32'h0000_003e;
  logic [15:0] hw[2][NUM_EP];
  uph_speed_type sp[2][NUM_EP];
  logic [25:0] rq[$];
  logic [19:0] tq[$];

  uph_top #(.NUM_EP(NUM_EP), .EP_W(EP_W), .STAT_W(8)) uph_top_i (.*, .id_host(1'b0));
  uph_link_model uph_link_model_i (.*);

  initial forever #2.5 mclk = ~mclk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checked++;
    if (e !== g) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask
  // strobes stand for exactly one edge
  task automatic clr();
    @(posedge mclk);
    {ping_wr, speed_wr, hub_wr, rd_req, stat_set, stat_clr} <= '0;
    {in_req, in_cancel, pwr_set, pwr_clr, fault_clr} <= '0;
  endtask
  task automatic hub(int e, int d);
    logic [31:0] r;
    r = xs();
    @(posedge mclk);
    {hub_wr, hub_ep, hub_dir, hub_word, hub_low_speed} <= {1'b1, e[2:0], d[0], r[16:0]};
    hw[d][e] = r[16:1];
    sp[d][e] = r[0] ? endpoint_low_speed_sel : endpoint_full_speed_sel;
    clr();
  endtask
  task automatic spd(int e, int d, uph_speed_type v);
    @(posedge mclk);
    {speed_wr, speed_ep, speed_dir, speed_val} <= {1'b1, e[2:0], d[0], v};
    sp[d][e] = v;
    clr();
  endtask
  task automatic rd(int e, int d, logic [7:0] s);
    @(posedge mclk);
    {rd_req, rd_ep, rd_dir} <= {1'b1, e[2:0], d[0]};
    rq.push_back({hw[d][e] & 16'h7f7f, sp[d][e], s});
    clr();
  endtask
  task automatic req(int e, int p, bit note, bit cancel);
    @(posedge mclk);
    {in_req, in_cancel, in_ep} <= {!cancel, cancel, e[2:0]};
    if (note) tq.push_back({e[2:0], sp[0][e], hw[0][e][6:0], hw[0][e][14:8], p[0]});
    clr();
  endtask
  task automatic drain();
    for (int i = 0; i < 500 && tq.size() != 0; i++) @(posedge mclk);
    chk("tx drained", 0, tq.size());
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // results against the oldest notes
  always @(negedge mclk) begin
    if (rd_valid === 1'b1) chk("read", rq.pop_front(), {rd_hub_word, rd_speed, rd_status});
    if (tx_start === 1'b1) chk("issue", tq.pop_front(), {tx_ep, tx_speed, tx_hub_addr,
      tx_hub_port, tx_ping});
  end

  // well under a thousand cycles needed
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    finish_test();
  end

  initial begin
    logic [31:0] r;
    cyc(12);
    rst <= 1'b0;
    host_force <= 1'b1;
    cyc(3);
    for (int e = 0; e < NUM_EP; e++) for (int d = 0; d < 2; d++) begin
      hub(e, d);
      rd(e, d, 8'h00);
    end
    spd(1, 1, endpoint_high_speed_sel);
    rd(1, 1, 8'h00);
    rd(1, 0, 8'h00);
    r = xs();
    @(posedge mclk);
    {stat_set, stat_set_ep, stat_set_bits} <= {1'b1, 3'h3, r[7:0]};
    clr();
    @(posedge mclk);
    {stat_clr, stat_clr_ep, stat_clr_mask} <= {1'b1, 3'h3, r[15:8]};
    clr();
    rd(3, 0, r[7:0] & ~r[15:8]);
    $display("test routing and status done");
    // ping: off-ep0 write ignored
    @(posedge mclk) {ping_wr, ping_ep, ping_val} <= {1'b1, 3'h3, 1'b0};
    clr();
    spd(0, 0, endpoint_high_speed_sel);
    req(0, 1, 1, 0);
    drain();
    {ping_wr, ping_ep, ping_val} <= {1'b1, 3'h0, 1'b0};
    clr();
    req(0, 0, 1, 0);
    drain();
    // slow link: lowest first, cancelled never
    slow <= 1'b1;
    req(4, 0, 1, 0);
    cyc(6);
    req(6, 0, 0, 0);
    req(5, 0, 1, 0);
    req(2, 0, 0, 0);
    tq.push_front({3'h2, sp[0][2], hw[0][2][6:0], hw[0][2][14:8], 1'b0});
    req(6, 0, 0, 1);
    drain();
    cyc(60);
    slow <= 1'b0;
    $display("test IN scheduling done");
    for (int m = 0; m < 4; m++) begin
      @(posedge mclk) {pwr_mode, session_active, pwr_clr} <= {m[1:0], 2'b01};
      clr();
      cyc(4);
      @(negedge mclk) chk("power off level", !m[0], external_power_enable_out);
      @(posedge mclk);
      if (m < 2) pwr_set <= 1'b1;
      else session_active <= 1'b1;
      clr();
      cyc(4);
      @(negedge mclk) chk("power on level", m[0], external_power_enable_out);
    end
    $display("test power modes done");
    for (int a = 0; a < 4; a++) begin
      @(posedge mclk);
      {fault_level, power_fault_input, fault_action, fault_det_en} <= {a[0], !a[0], a[1:0], 1'b1};
      cyc(3);
      power_fault_input <= a[0];
      cyc(3);
      @(negedge mclk) chk("fault seen", 1, fault_status);
      chk("fault oe", a != 1, external_power_enable_oe);
      if (a != 1) chk("fault level", a != 2, external_power_enable_out);
      @(posedge mclk);
      {power_fault_input, fault_clr} <= {!a[0], 1'b1};
      clr();
      cyc(2);
      @(negedge mclk) chk("fault cleared", 0, fault_status);
      @(posedge mclk);
      {fault_det_en, power_fault_input} <= {1'b0, a[0]};
      cyc(3);
      @(negedge mclk) chk("detect off", 3'b011, {fault_status, external_power_enable_oe,
        external_power_enable_out});
    end
    $display("test power fault done");
    @(posedge mclk);
    {vbus_glitch_filter_en, vbus_valid_raw} <= 2'b10;
    cyc(150);
    @(negedge mclk) chk("short drop", 0, vbus_error);
    @(posedge mclk) vbus_valid_raw <= 1'b1;
    cyc(5);
    vbus_valid_raw <= 1'b0;
    cyc(210);
    @(negedge mclk) chk("long drop", 1, vbus_error);
    @(posedge mclk) {vbus_glitch_filter_en, vbus_valid_raw} <= 2'b01;
    cyc(5);
    vbus_valid_raw <= 1'b0;
    cyc(3);
    @(negedge mclk) chk("unfiltered drop", 1, vbus_error);
    $display("test vbus filter done");
    finish_test();
  end
endmodule // tb

bind uph_top uph_top_properties #(.NUM_EP(NUM_EP), .EP_W(EP_W)) uph_top_properties_i (.*);
